// file: core/wdt_pkg.sv
package wdt_pkg;

   // Register byte offsets
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_FLAGS = 5'h04;
   localparam logic [4:0] OFF_SCC = 5'h08;
   localparam logic [4:0] OFF_ISTAT = 5'h0C;
   localparam logic [4:0] OFF_IMASK = 5'h10;
   localparam logic [4:0] OFF_STATUS = 5'h14;

   // Field positions
   localparam int KEY_LSB = 3;
   localparam int SEL_LSB = 0;
   localparam int KEYFLAG_BIT = 0;
   localparam int SLOWSEL_BIT = 0;
   localparam int EV_TIMEOUT = 0;
   localparam int EV_KEYFAULT = 1;
   localparam int ST_EXPIRED = 0;
   localparam int ST_PDOWN = 1;
   localparam int ST_ENABLED = 2;

   // Key codes and reset values
   localparam logic [4:0] KEY_ENABLE = 5'h0A;
   localparam logic [4:0] KEY_DISABLE = 5'h15;
   localparam logic [2:0] SEL_RESET = 3'h3;
   localparam logic SLOWSEL_RESET = 1'b0;
   localparam logic [1:0] IMASK_RESET = 2'h0;

   // Timing counts
   localparam int CNT_W = 18;
   localparam logic [1:0] FAULT_TICKS = 2'h2;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: core/watchdog_timer.sv
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module watchdog_timer
   import wdt_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   // Slow tick enables, one clk cycle each
   input wire logic crystal_tick,
   input wire logic low_rc_tick,
   // Processor core side
   input wire logic clear_instr,
   input wire logic halt_instr,
   input wire logic halted,
   input wire logic external_clear_pin_n,
   output logic sys_reset,
   output logic pc_sp_reset,
   output logic pc_clear,
   output logic port_preset,
   output logic watchdog_expired_flag,
   output logic power_down_flag,
   output logic irq,
   // AXI4-Lite slave
   input wire logic [4:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [4:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   typedef struct packed {
      logic [4:0] key;
      logic [2:0] sel;
      logic slow_sel;
      logic key_flag;
      logic expired;
      logic pdown;
      logic [CNT_W-1:0] count;
      logic [1:0] fault_cnt;
      logic [1:0] istat;
      logic [1:0] imask;
      logic irq;
      logic sys_reset;
      logic pc_sp_reset;
      logic pc_clear;
      logic port_preset;
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [4:0] aw_addr;
      logic [7:0] w_byte;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic tick;
   logic enabled;
   logic key_bad;
   logic key_fire;
   logic timeout_evt;
   logic count_clear;
   logic wr_fire;
   logic [CNT_W-1:0] term;
   logic [4:0] shift;
   logic [CNT_W:0] span;
   logic [31:0] rd_val;
   logic rd_hit;

   // Tick source and enable decode
   always_comb begin
      tick = st_reg.slow_sel ? crystal_tick : low_rc_tick;
      enabled = (st_reg.key == KEY_ENABLE);
      key_bad = !enabled && (st_reg.key != KEY_DISABLE);
      // One to two RC periods: the fault is seen between ticks
      key_fire = key_bad && low_rc_tick && (st_reg.fault_cnt == FAULT_TICKS - 2'h1);
   end

   // Terminal count is one below the selected power of two
   always_comb begin
      if (st_reg.sel[2]) begin
         shift = 5'(5'h0B + {2'h0, st_reg.sel});
      end else begin
         shift = 5'(5'h08 + {1'b0, st_reg.sel, 1'b0});
      end
      span = (19'h00001 << shift) - 19'h00001;
      term = span[CNT_W-1:0];
   end

   // Timeout and clear conditions
   always_comb begin
      // At or past the terminal, so a shortened period still expires
      timeout_evt = enabled && tick && (st_reg.count >= term);
      // Instruction clears keep the dog alive
      count_clear = !external_clear_pin_n || clear_instr || halt_instr;
      wr_fire = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
   end

   // Read mux; unused upper bits read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (araddr)
         OFF_CTRL: begin
            rd_val[7:0] = {st_reg.key, st_reg.sel};
         end
         OFF_FLAGS: begin
            rd_val[KEYFLAG_BIT] = st_reg.key_flag;
         end
         OFF_SCC: begin
            rd_val[SLOWSEL_BIT] = st_reg.slow_sel;
         end
         OFF_ISTAT: begin
            rd_val[1:0] = st_reg.istat;
         end
         OFF_IMASK: begin
            rd_val[1:0] = st_reg.imask;
         end
         OFF_STATUS: begin
            rd_val[ST_EXPIRED] = st_reg.expired;
            rd_val[ST_PDOWN] = st_reg.pdown;
            rd_val[ST_ENABLED] = enabled;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // Whole next state
   always_comb begin
      st_next = st_reg;
      st_next.sys_reset = 1'b0;
      st_next.pc_sp_reset = 1'b0;
      st_next.port_preset = 1'b0;

      // Write channels are taken independently
      if (awvalid && st_reg.awready) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = awaddr;
      end
      if (wvalid && st_reg.wready) begin
         st_next.w_have = 1'b1;
         st_next.w_byte = wdata[7:0];
         st_next.w_lane0 = wstrb[0];
      end

      // Register write once both halves are in
      if (wr_fire) begin
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = RESP_OKAY;
         case (st_reg.aw_addr)
            OFF_CTRL: begin
               if (st_reg.w_lane0) begin
                  st_next.key = st_reg.w_byte[KEY_LSB +: 5];
                  st_next.sel = st_reg.w_byte[SEL_LSB +: 3];
               end
            end
            OFF_FLAGS: begin
               // Writing one leaves the flag alone
               if (st_reg.w_lane0 && !st_reg.w_byte[KEYFLAG_BIT]) begin
                  st_next.key_flag = 1'b0;
               end
            end
            OFF_SCC: begin
               if (st_reg.w_lane0) begin
                  st_next.slow_sel = st_reg.w_byte[SLOWSEL_BIT];
               end
            end
            OFF_ISTAT: begin
               if (st_reg.w_lane0) begin
                  st_next.istat = st_reg.istat & ~st_reg.w_byte[1:0];
               end
            end
            OFF_IMASK: begin
               if (st_reg.w_lane0) begin
                  st_next.imask = st_reg.w_byte[1:0];
               end
            end
            OFF_STATUS: begin
               st_next.bresp = RESP_OKAY;
            end
            default: begin
               st_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_reg.bvalid && bready) begin
         st_next.bvalid = 1'b0;
      end
      st_next.awready = !st_next.aw_have && !st_next.bvalid;
      st_next.wready = !st_next.w_have && !st_next.bvalid;

      // Read channel: one outstanding read
      if (arvalid && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.arready = 1'b0;
         st_next.rdata = rd_val;
         st_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (st_reg.rvalid && rready) begin
         st_next.rvalid = 1'b0;
         st_next.arready = 1'b1;
      end

      // Fault delay counts RC ticks only while the key is bad
      if (!key_bad || key_fire) begin
         st_next.fault_cnt = 2'h0;
      end else if (low_rc_tick) begin
         st_next.fault_cnt = st_reg.fault_cnt + 2'h1;
      end

      // Tick counter; any clear beats a tick
      if (count_clear || key_fire || timeout_evt) begin
         st_next.count = '0;
      end else if (enabled && tick) begin
         st_next.count = st_reg.count + 1'b1;
      end

      // Status flags: clears first so a set in the same cycle wins
      if (clear_instr) begin
         st_next.pdown = 1'b0;
      end
      if (halt_instr) begin
         st_next.pdown = 1'b1;
         st_next.expired = 1'b0;
      end
      if (timeout_evt) begin
         st_next.expired = 1'b1;
         st_next.istat[EV_TIMEOUT] = 1'b1;
         if (halted) begin
            st_next.pc_sp_reset = 1'b1;
         end else begin
            st_next.sys_reset = 1'b1;
         end
      end

      // Bad key: reset, raise sticky flag, restore power-up control
      if (key_fire) begin
         st_next.sys_reset = 1'b1;
         st_next.key_flag = 1'b1;
         st_next.key = KEY_ENABLE;
         st_next.sel = SEL_RESET;
         st_next.istat[EV_KEYFAULT] = 1'b1;
      end

      // Program counter goes to zero on every reset source
      st_next.pc_clear = key_fire || timeout_evt || !external_clear_pin_n;
      st_next.irq = |(st_next.istat & st_next.imask);
   end

   // State register; reset value is the power-on state
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.key <= KEY_ENABLE;
         st_reg.sel <= SEL_RESET;
         st_reg.slow_sel <= SLOWSEL_RESET;
         st_reg.imask <= IMASK_RESET;
         st_reg.pc_clear <= 1'b1;
         st_reg.port_preset <= 1'b1;
         st_reg.awready <= 1'b1;
         st_reg.wready <= 1'b1;
         st_reg.arready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign sys_reset = st_reg.sys_reset;
   assign pc_sp_reset = st_reg.pc_sp_reset;
   assign pc_clear = st_reg.pc_clear;
   assign port_preset = st_reg.port_preset;
   assign watchdog_expired_flag = st_reg.expired;
   assign power_down_flag = st_reg.pdown;
   assign irq = st_reg.irq;
   assign awready = st_reg.awready;
   assign wready = st_reg.wready;
   assign bvalid = st_reg.bvalid;
   assign bresp = st_reg.bresp;
   assign arready = st_reg.arready;
   assign rvalid = st_reg.rvalid;
   assign rdata = st_reg.rdata;
   assign rresp = st_reg.rresp;

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_run_timeout;
      timeout_evt && !halted;
   endsequence

   sequence s_halt_timeout;
      timeout_evt && halted;
   endsequence

   sequence s_wd_reset_out;
      st_reg.sys_reset && st_reg.expired && st_reg.pc_clear;
   endsequence

   a_por_defaults: assert property ($fell(srst) |->
      st_reg.key == KEY_ENABLE && st_reg.sel == SEL_RESET && st_reg.port_preset)
      else $error("power-up control value wrong");

   a_count_bound: assert property (
      ($stable(st_reg.sel) && $past(st_reg.count) <= $past(term)) |-> st_reg.count <= term)
      else $error("count passed selected terminal");

   a_term_reset: assert property ((st_reg.sel == SEL_RESET) |-> term == 18'h03FFF)
      else $error("power-up timeout period wrong");

   a_disabled_hold: assert property ((st_reg.key == KEY_DISABLE && !count_clear) |=>
      $stable(st_reg.count))
      else $error("count moved while disabled");

   a_key_fault: assert property ((key_bad && st_reg.fault_cnt == 2'h1 && low_rc_tick) |=>
      st_reg.sys_reset ##1 !st_reg.sys_reset)
      else $error("bad key did not reset on second tick");

   a_key_flag_set: assert property (key_fire |=> st_reg.key_flag && st_reg.pc_clear)
      else $error("key reset flag not set");

   a_key_flag_keep: assert property ((st_reg.key_flag && !wr_fire) |=> st_reg.key_flag)
      else $error("key reset flag lost without write");

   a_run_timeout: assert property (s_run_timeout |=> s_wd_reset_out)
      else $error("running timeout did not reset");

   a_halt_timeout: assert property (s_halt_timeout |=>
      st_reg.pc_sp_reset && !st_reg.sys_reset && st_reg.expired)
      else $error("halted timeout gave wrong reset");

   a_count_clear: assert property (count_clear |=> st_reg.count == '0)
      else $error("count not cleared");

   a_pin_clear: assert property (!external_clear_pin_n |=>
      st_reg.pc_clear && st_reg.count == '0)
      else $error("reset pin did not clear");

   a_halt_flags: assert property ((halt_instr && !timeout_evt) |=>
      st_reg.pdown && !st_reg.expired)
      else $error("halt flags wrong");

   a_rsv_zero: assert property ((arvalid && arready && araddr == OFF_FLAGS) |=>
      st_reg.rvalid && st_reg.rdata[31:1] == 31'h0)
      else $error("reserved flag bits not zero");

endmodule // watchdog_timer

// file: tb/core_model.sv
`timescale 1ns/10ps
// Processor core stand-in: issues clear and halt, sleeps until a wake
module core_model (
   input wire logic clk,
   input wire logic wake,
   output logic clear_instr,
   output logic halt_instr,
   output logic halted
);
   initial begin
      clear_instr = 1'b0;
      halt_instr = 1'b0;
      halted = 1'b0;
   end
   // Any watchdog reset ends the sleep
   always @(posedge clk) begin
      if (wake === 1'b1) halted <= 1'b0;
   end
   // Single clear instruction keeps the dog alive
   task automatic clear_pulse();
      @(posedge clk);
      clear_instr <= 1'b1;
      @(posedge clk);
      clear_instr <= 1'b0;
   endtask
   // Halt enters sleep in the same step
   task automatic halt_pulse();
      @(posedge clk);
      halt_instr <= 1'b1;
      halted <= 1'b1;
      @(posedge clk);
      halt_instr <= 1'b0;
   endtask
endmodule // core_model

// file: tb/watchdog_timer_reset_flags_tb.sv
`timescale 1ns/10ps
module watchdog_timer_reset_flags_tb;
   import wdt_pkg::*;
   logic clk = 1'b0, srst = 1'b1, xt = 1'b0, rc = 1'b0, pin_n = 1'b1;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sys_reset, pc_sp_reset, pc_clear;
   logic port_preset, expired, pdown, irq, clr_i, halt_i, halted;
   logic [1:0] bresp, rresp, r;
   logic [31:0] d;
   int bad_count = 0, comparisons = 0, nsys = 0, npc = 0, cyc = 0;
   always #25 clk = ~clk;
   watchdog_timer uut (.clk(clk), .srst(srst), .crystal_tick(xt), .low_rc_tick(rc),
      .clear_instr(clr_i), .halt_instr(halt_i), .halted(halted),
      .external_clear_pin_n(pin_n), .sys_reset(sys_reset), .pc_sp_reset(pc_sp_reset),
      .pc_clear(pc_clear), .port_preset(port_preset), .watchdog_expired_flag(expired),
      .power_down_flag(pdown), .irq(irq), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   core_model core (.clk(clk), .wake(sys_reset | pc_sp_reset), .clear_instr(clr_i),
      .halt_instr(halt_i), .halted(halted));
   // Reset pulse counters and hang guard; longest test is a few thousand cycles
   always @(posedge clk) begin
      if (sys_reset === 1'b1) nsys++;
      if (pc_sp_reset === 1'b1) npc++;
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // Each channel released at its own handshake
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic w(input logic [4:0] a, input logic [31:0] v);
      wr(a, v, r);
   endtask
   task automatic expect_rd(input string name, input logic [4:0] a, input logic [31:0] v);
      rd(a, d, r);
      check(name, d, v);
   endtask
   // Slow ticks with a gap cycle, then room for the reset pulse
   task automatic ticks(input int n, input bit crystal);
      repeat (n) begin
         @(posedge clk);
         if (crystal) xt <= 1'b1;
         else rc <= 1'b1;
         @(posedge clk);
         xt <= 1'b0;
         rc <= 1'b0;
      end
      repeat (3) @(posedge clk);
   endtask
   task automatic test_reset_values();
      check("port_preset", port_preset, 1'b1);
      check("pc_clear", pc_clear, 1'b1);
      expect_rd("ctrl", OFF_CTRL, 32'h53);
      wr(OFF_STATUS, 32'h7, r);
      check("status wr resp", r, RESP_OKAY);
      expect_rd("status", OFF_STATUS, 32'h4);
      wr(5'h18, 32'hFF, r);
      check("unmapped wr resp", r, RESP_SLVERR);
      rd(5'h18, d, r);
      check("unmapped", d, 32'h0);
      check("unmapped resp", r, RESP_SLVERR);
      check("port_preset low", port_preset, 1'b0);
      $display("test reset_values done");
   endtask
   task automatic test_timeout();
      w(OFF_IMASK, 32'h1);
      // Shortest two periods: one tick short, then the last tick
      for (int s = 0; s < 2; s++) begin
         w(OFF_CTRL, {KEY_ENABLE, s[2:0]});
         nsys = 0;
         ticks((1 << (8 + 2 * s)) - 1, 1'b0);
         check("early", nsys, 0);
         ticks(1, 1'b0);
         check("timeout", nsys, 1);
         check("expired", expired, 1'b1);
      end
      check("irq", irq, 1'b1);
      w(OFF_ISTAT, 32'h1);
      check("irq cleared", irq, 1'b0);
      $display("test timeout done");
   endtask
   task automatic test_disable_and_source();
      w(OFF_CTRL, {KEY_DISABLE, 3'h0});
      nsys = 0;
      ticks(300, 1'b0);
      check("disabled", nsys, 0);
      w(OFF_SCC, 32'h1);
      w(OFF_CTRL, {KEY_ENABLE, 3'h0});
      ticks(300, 1'b0);
      check("rc ignored", nsys, 0);
      ticks(256, 1'b1);
      check("crystal", nsys, 1);
      w(OFF_ISTAT, 32'h1);
      w(OFF_SCC, 32'h0);
      $display("test disable_and_source done");
   endtask
   task automatic test_bad_key();
      w(OFF_CTRL, 32'h00);
      nsys = 0;
      ticks(1, 1'b0);
      check("one tick", nsys, 0);
      ticks(1, 1'b0);
      check("key reset", nsys, 1);
      check("irq masked", irq, 1'b0);
      expect_rd("istat key", OFF_ISTAT, 32'h2);
      expect_rd("flags", OFF_FLAGS, 32'h1);
      expect_rd("ctrl back", OFF_CTRL, 32'h53);
      w(OFF_FLAGS, 32'hFF);
      expect_rd("flags kept", OFF_FLAGS, 32'h1);
      w(OFF_FLAGS, 32'h0);
      expect_rd("flags clear", OFF_FLAGS, 32'h0);
      $display("test bad_key done");
   endtask
   task automatic test_clears_and_halt();
      w(OFF_CTRL, {KEY_ENABLE, 3'h0});
      nsys = 0;
      npc = 0;
      ticks(200, 1'b0);
      core.clear_pulse();
      ticks(200, 1'b0);
      check("clear", nsys, 0);
      @(posedge clk);
      pin_n <= 1'b0;
      repeat (3) @(posedge clk);
      check("pin pc_clear", pc_clear, 1'b1);
      pin_n <= 1'b1;
      ticks(200, 1'b0);
      check("pin clear", nsys, 0);
      expect_rd("ctrl kept", OFF_CTRL, 32'h50);
      core.halt_pulse();
      repeat (2) @(posedge clk);
      check("pdown", pdown, 1'b1);
      check("expired off", expired, 1'b0);
      ticks(256, 1'b0);
      check("halt no full reset", nsys, 0);
      check("halt pc reset", npc, 1);
      check("expired", expired, 1'b1);
      core.clear_pulse();
      repeat (2) @(posedge clk);
      check("pdown off", pdown, 1'b0);
      $display("test clears_and_halt done");
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      test_reset_values();
      test_timeout();
      test_disable_and_source();
      test_bad_key();
      test_clears_and_halt();
      conclude();
   end
endmodule // watchdog_timer_reset_flags_tb
